// ===== hw/port_pin_map.vh
// Register offsets, field positions and reset values of the port pin mode control block.
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH
// Byte offsets on the APB window (low 12 bits decoded).
`define OFF_P4_LATCH 12'h000
`define OFF_P5_LATCH 12'h004
`define OFF_P7_LATCH 12'h008
`define OFF_P4_DIR 12'h010
`define OFF_P5_DIR 12'h014
`define OFF_P7_DIR 12'h018
`define OFF_P2_DIR 12'h01C
`define OFF_P4_PULLUP 12'h020
`define OFF_P5_PULLUP 12'h024
`define OFF_P7_PULLUP 12'h028
`define OFF_P4_ANALOG 12'h030
`define OFF_P5_ANALOG 12'h034
`define OFF_P7_ANALOG 12'h038
`define OFF_P5_OUTTYPE 12'h040
`define OFF_P4_READ 12'h050
`define OFF_P5_READ 12'h054
`define OFF_P7_READ 12'h058
// The switch register sits at word index F0076h; its byte address is four times that.
`define IDX_ANALOG_SWITCH 20'hF0076
`define OFF_ANALOG_SWITCH 12'h1D8
// Port widths.
`define P4_W 3
`define P5_W 2
`define P7_W 4
`define P2_W 5
// Reset values: direction set means input.
`define DIR_RESET_P4 3'h7
`define DIR_RESET_P5 2'h3
`define DIR_RESET_P7 4'hF
`define DIR_RESET_P2 5'h1F
`define ANALOG_SWITCH_RESET 3'h0
`define ANALOG_SWITCH_W 3
// Analog-capable bit masks, then the open-drain-capable mask of port 5.
`define P4_ANALOG_MASK 3'h2
`define P5_ANALOG_MASK 2'h3
`define P7_ANALOG_MASK 4'h1
`define P5_OUTTYPE_MASK 2'h1
`endif

// ===== hw/pin_switch_decode.v
// Decoder from the analog/digital switch field to a per-pin analog mask.
`timescale 1ns/1ps
`default_nettype none
module pin_switch_decode (
    // Switch field.
    input wire [2:0] sel,
    // One bit per shared pin, high means analog.
    output reg [4:0] analog_mask
);
    // Prohibited codes fall back to all digital so no pin is left half set.
    always @* begin
        case (sel)
            3'h0: analog_mask = 5'h1F;
            3'h1: analog_mask = 5'h00;
            3'h2: analog_mask = 5'h01;
            3'h3: analog_mask = 5'h03;
            3'h4: analog_mask = 5'h07;
            3'h5: analog_mask = 5'h0F;
            default: analog_mask = 5'h00;
        endcase
    end
endmodule
`default_nettype wire

// ===== hw/port_pin_mode_control.v
// APB-controlled pin mode logic for ports 4, 5 and 7 and the shared converter pins.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.vh"
module port_pin_mode_control #(
    parameter P4_W = `P4_W,
    parameter P5_W = `P5_W,
    parameter P7_W = `P7_W
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Port 4 pins.
    input wire [P4_W-1:0] port4_in,
    output reg [P4_W-1:0] port4_out,
    output reg [P4_W-1:0] port4_oe,
    output reg [P4_W-1:0] port4_pullup,
    output reg [P4_W-1:0] port4_analog,
    // Port 5 pins.
    input wire [P5_W-1:0] port5_in,
    output reg [P5_W-1:0] port5_out,
    output reg [P5_W-1:0] port5_oe,
    output reg [P5_W-1:0] port5_pullup,
    output reg [P5_W-1:0] port5_analog,
    // Port 7 pins.
    input wire [P7_W-1:0] port7_in,
    output reg [P7_W-1:0] port7_out,
    output reg [P7_W-1:0] port7_oe,
    output reg [P7_W-1:0] port7_pullup,
    output reg [P7_W-1:0] port7_analog,
    // Shared converter pins (port 2).
    output reg [4:0] shared_analog,
    output reg [4:0] port2_input_mode
);
    // Software-visible state.
    reg [P4_W-1:0] p4_latch_q, p4_dir_q, p4_pu_q, p4_an_q;
    reg [P5_W-1:0] p5_latch_q, p5_dir_q, p5_pu_q, p5_an_q, p5_ot_q;
    reg [P7_W-1:0] p7_latch_q, p7_dir_q, p7_pu_q, p7_an_q;
    reg [4:0] p2_dir_q;
    reg [2:0] sw_q;
    wire [4:0] sw_mask;
    wire wr_en;
    reg [31:0] rd_d;
    reg hit_d;
    reg [P4_W-1:0] p4_view;
    reg [P5_W-1:0] p5_view;
    reg [P7_W-1:0] p7_view;

    // A write lands at the edge where the master sees pready, never earlier, so a
    // transfer that is dropped before the answer leaves the registers untouched.
    assign wr_en = psel & penable & pwrite & pready;

    pin_switch_decode u_dec (
        .sel(sw_q),
        .analog_mask(sw_mask)
    );

    // Read view: input pins pass through, outputs echo the latch, analog bits read zero.
    always @* begin
        p4_view = ((port4_in & p4_dir_q) | (p4_latch_q & ~p4_dir_q)) & ~p4_an_q;
        p5_view = ((port5_in & p5_dir_q) | (p5_latch_q & ~p5_dir_q)) & ~p5_an_q;
        p7_view = ((port7_in & p7_dir_q) | (p7_latch_q & ~p7_dir_q)) & ~p7_an_q;
    end

    // Port 4 registers. Direction resets to input so no pin drives before software asks.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p4_latch_q <= {P4_W{1'b0}};
            p4_dir_q <= {P4_W{1'b1}};
            p4_pu_q <= {P4_W{1'b0}};
            p4_an_q <= {P4_W{1'b0}};
        end else if (wr_en) begin
            if (paddr == `OFF_P4_LATCH) begin
                p4_latch_q <= pwdata[P4_W-1:0];
            end else if (paddr == `OFF_P4_DIR) begin
                p4_dir_q <= pwdata[P4_W-1:0];
            end else if (paddr == `OFF_P4_PULLUP) begin
                p4_pu_q <= pwdata[P4_W-1:0];
            end else if (paddr == `OFF_P4_ANALOG) begin
                // Only the analog-capable pin keeps a set bit; the others read back zero.
                p4_an_q <= pwdata[P4_W-1:0] & `P4_ANALOG_MASK;
            end
        end
    end

    // Port 5 registers, including the output type of the one pin with an open-drain stage.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p5_latch_q <= {P5_W{1'b0}};
            p5_dir_q <= {P5_W{1'b1}};
            p5_pu_q <= {P5_W{1'b0}};
            p5_an_q <= {P5_W{1'b0}};
            p5_ot_q <= {P5_W{1'b0}};
        end else if (wr_en) begin
            if (paddr == `OFF_P5_LATCH) begin
                p5_latch_q <= pwdata[P5_W-1:0];
            end else if (paddr == `OFF_P5_DIR) begin
                p5_dir_q <= pwdata[P5_W-1:0];
            end else if (paddr == `OFF_P5_PULLUP) begin
                p5_pu_q <= pwdata[P5_W-1:0];
            end else if (paddr == `OFF_P5_ANALOG) begin
                p5_an_q <= pwdata[P5_W-1:0] & `P5_ANALOG_MASK;
            end else if (paddr == `OFF_P5_OUTTYPE) begin
                // Pin 1 has no open-drain stage, so its bit is never stored.
                p5_ot_q <= pwdata[P5_W-1:0] & `P5_OUTTYPE_MASK;
            end
        end
    end

    // Port 7 registers. Unmapped writes fall through every branch and change nothing.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p7_latch_q <= {P7_W{1'b0}};
            p7_dir_q <= {P7_W{1'b1}};
            p7_pu_q <= {P7_W{1'b0}};
            p7_an_q <= {P7_W{1'b0}};
        end else if (wr_en) begin
            if (paddr == `OFF_P7_LATCH) begin
                p7_latch_q <= pwdata[P7_W-1:0];
            end else if (paddr == `OFF_P7_DIR) begin
                p7_dir_q <= pwdata[P7_W-1:0];
            end else if (paddr == `OFF_P7_PULLUP) begin
                p7_pu_q <= pwdata[P7_W-1:0];
            end else if (paddr == `OFF_P7_ANALOG) begin
                p7_an_q <= pwdata[P7_W-1:0] & `P7_ANALOG_MASK;
            end
        end
    end

    // Port 2 direction; software must keep converter channel pins in input mode.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p2_dir_q <= `DIR_RESET_P2;
        end else if (wr_en) begin
            if (paddr == `OFF_P2_DIR) begin
                p2_dir_q <= pwdata[4:0];
            end
        end
    end

    // Analog/digital switch; starts all analog so no shared pin drives out of reset.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_q <= `ANALOG_SWITCH_RESET;
        end else if (wr_en) begin
            if (paddr == `OFF_ANALOG_SWITCH) begin
                // Upper bits are not stored, so a careless write cannot reach them.
                sw_q <= pwdata[2:0];
            end
        end
    end

    // Read mux; ports 3 and 6 have no address and answer with an error.
    always @* begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        if (paddr == `OFF_P4_LATCH) begin
            rd_d[P4_W-1:0] = p4_latch_q;
        end else if (paddr == `OFF_P5_LATCH) begin
            rd_d[P5_W-1:0] = p5_latch_q;
        end else if (paddr == `OFF_P7_LATCH) begin
            rd_d[P7_W-1:0] = p7_latch_q;
        end else if (paddr == `OFF_P4_DIR) begin
            rd_d[P4_W-1:0] = p4_dir_q;
        end else if (paddr == `OFF_P5_DIR) begin
            rd_d[P5_W-1:0] = p5_dir_q;
        end else if (paddr == `OFF_P7_DIR) begin
            rd_d[P7_W-1:0] = p7_dir_q;
        end else if (paddr == `OFF_P2_DIR) begin
            rd_d[4:0] = p2_dir_q;
        end else if (paddr == `OFF_P4_PULLUP) begin
            rd_d[P4_W-1:0] = p4_pu_q;
        end else if (paddr == `OFF_P5_PULLUP) begin
            rd_d[P5_W-1:0] = p5_pu_q;
        end else if (paddr == `OFF_P7_PULLUP) begin
            rd_d[P7_W-1:0] = p7_pu_q;
        end else if (paddr == `OFF_P4_ANALOG) begin
            rd_d[P4_W-1:0] = p4_an_q;
        end else if (paddr == `OFF_P5_ANALOG) begin
            rd_d[P5_W-1:0] = p5_an_q;
        end else if (paddr == `OFF_P7_ANALOG) begin
            rd_d[P7_W-1:0] = p7_an_q;
        end else if (paddr == `OFF_P5_OUTTYPE) begin
            rd_d[P5_W-1:0] = p5_ot_q;
        end else if (paddr == `OFF_P4_READ) begin
            rd_d[P4_W-1:0] = p4_view;
        end else if (paddr == `OFF_P5_READ) begin
            rd_d[P5_W-1:0] = p5_view;
        end else if (paddr == `OFF_P7_READ) begin
            rd_d[P7_W-1:0] = p7_view;
        end else if (paddr == `OFF_ANALOG_SWITCH) begin
            rd_d[2:0] = sw_q;
        end else begin
            hit_d = 1'b0;
        end
    end

    // APB answer: pready pulses one cycle into the access phase, so every transfer
    // takes one wait state. The registered answer keeps prdata off the address path,
    // at the cost of that extra cycle per access.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= ~hit_d;
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // Next values of the gated pin controls, kept apart so each gate is written once.
    wire [P4_W-1:0] port4_oe_d;
    wire [P4_W-1:0] port4_pullup_d;
    wire [P5_W-1:0] port5_out_d;
    wire [P5_W-1:0] port5_oe_d;
    wire [P5_W-1:0] port5_pullup_d;
    wire [P7_W-1:0] port7_oe_d;
    wire [P7_W-1:0] port7_pullup_d;

    // Open-drain bits enable the driver only to pull low, so a 1 floats.
    assign port4_oe_d = ~p4_dir_q & ~p4_an_q;
    assign port4_pullup_d = p4_pu_q & p4_dir_q & ~p4_an_q;
    assign port5_out_d = p5_latch_q & ~p5_ot_q;
    assign port5_oe_d = ~p5_dir_q & ~p5_an_q & ~(p5_ot_q & p5_latch_q);
    assign port5_pullup_d = p5_pu_q & p5_dir_q & ~p5_an_q;
    assign port7_oe_d = ~p7_dir_q & ~p7_an_q;
    assign port7_pullup_d = p7_pu_q & p7_dir_q & ~p7_an_q;

    // Port 4 pin drive. A pin set analog drops both its driver and its pull-up.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port4_out <= {P4_W{1'b0}};
            port4_oe <= {P4_W{1'b0}};
            port4_pullup <= {P4_W{1'b0}};
            port4_analog <= {P4_W{1'b0}};
        end else begin
            port4_out <= p4_latch_q;
            port4_oe <= port4_oe_d;
            port4_pullup <= port4_pullup_d;
            port4_analog <= p4_an_q;
        end
    end

    // Port 5 pin drive; pin outputs lag their registers by one cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port5_out <= {P5_W{1'b0}};
            port5_oe <= {P5_W{1'b0}};
            port5_pullup <= {P5_W{1'b0}};
            port5_analog <= {P5_W{1'b0}};
        end else begin
            port5_out <= port5_out_d;
            port5_oe <= port5_oe_d;
            port5_pullup <= port5_pullup_d;
            port5_analog <= p5_an_q;
        end
    end

    // Port 7 pin drive.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port7_out <= {P7_W{1'b0}};
            port7_oe <= {P7_W{1'b0}};
            port7_pullup <= {P7_W{1'b0}};
            port7_analog <= {P7_W{1'b0}};
        end else begin
            port7_out <= p7_latch_q;
            port7_oe <= port7_oe_d;
            port7_pullup <= port7_pullup_d;
            port7_analog <= p7_an_q;
        end
    end

    // Shared converter pins: the reset value matches the all-analog decode of code 0.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_analog <= 5'h1F;
            port2_input_mode <= 5'h1F;
        end else begin
            shared_analog <= sw_mask;
            port2_input_mode <= p2_dir_q;
        end
    end
endmodule
`default_nettype wire

// ===== verif/port_pin_checker.sv
// Concurrent checks on the ports of the port pin mode control block.
`timescale 1ns/1ps
`default_nettype none
module port_pin_checker (
    // Clock, reset and bus answer.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pin controls.
    input wire logic [2:0] port4_oe,
    input wire logic [2:0] port4_pullup,
    input wire logic [2:0] port4_analog,
    input wire logic [1:0] port5_pullup,
    input wire logic [1:0] port5_analog,
    input wire logic [3:0] port7_oe,
    input wire logic [3:0] port7_analog,
    input wire logic [4:0] shared_analog
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answer shape, then pin rules; a pull-up on a driven pin would waste current.
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside the answer cycle");
    pullup_drive_a: assert property ((port4_oe & port4_pullup) == 3'h0)
        else $error("port 4 pull-up on an output pin");
    pullup_analog_a: assert property ((port5_pullup & port5_analog) == 2'h0)
        else $error("port 5 pull-up on an analog pin");
    analog_drive_a: assert property ((port7_oe & port7_analog) == 4'h0)
        else $error("port 7 analog pin driven");
    p4_capable_a: assert property ((port4_analog & 3'h5) == 3'h0)
        else $error("port 4 analog on an incapable pin");
    p7_capable_a: assert property (port7_analog[3:1] == 3'h0)
        else $error("port 7 analog on an incapable pin");
    switch_code_a: assert property (shared_analog inside {5'h1F, 5'h00, 5'h01, 5'h03, 5'h07, 5'h0F})
        else $error("shared pin pattern not a legal decode");
    cover property (pslverr);
    cover property (port4_oe == 3'h7);
    cover property (shared_analog == 5'h0F);
endmodule
bind port_pin_mode_control port_pin_checker port_pin_checker_inst (.*);
`default_nettype wire

// ===== verif/pin_board.sv
// Board model at one port: external level, resolved with the device's driver and pull-up.
`timescale 1ns/1ps
`default_nettype none
module pin_board #(
    parameter W = 3
) (
    // Device side.
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pull_on,
    // Board side.
    input wire logic [W-1:0] ext,
    output logic [W-1:0] pin
);
    // A driven pin wins; an undriven pin with pull-up reads high, else the board level.
    assign pin = (oe & out) | (~oe & pull_on) | (~oe & ~pull_on & ext);
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the port pin mode control block.
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr;
    logic [2:0] ext4 = 3'h2;
    logic [1:0] ext5 = 2'h2;
    logic [3:0] ext7 = 4'h5;
    wire [2:0] o4, oe4, pu4, an4, pin4;
    wire [1:0] o5, oe5, pu5, an5, pin5;
    wire [3:0] o7, oe7, pu7, an7, pin7;
    wire [4:0] shared_analog, port2_input_mode;
    int n_fail = 0, comparisons = 0, cyc = 0;
    logic er;
    port_pin_mode_control port_pin_mode_control_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port4_in(pin4), .port4_out(o4),
        .port4_oe(oe4), .port4_pullup(pu4), .port4_analog(an4), .port5_in(pin5),
        .port5_out(o5), .port5_oe(oe5), .port5_pullup(pu5), .port5_analog(an5),
        .port7_in(pin7), .port7_out(o7), .port7_oe(oe7), .port7_pullup(pu7),
        .port7_analog(an7), .shared_analog(shared_analog), .port2_input_mode(port2_input_mode));
    pin_board #(.W(3)) b4 (.out(o4), .oe(oe4), .pull_on(pu4), .ext(ext4), .pin(pin4));
    pin_board #(.W(2)) b5 (.out(o5), .oe(oe5), .pull_on(pu5), .ext(ext5), .pin(pin5));
    pin_board #(.W(4)) b7 (.out(o7), .oe(oe7), .pull_on(pu7), .ext(ext7), .pin(pin7));
    // Clock, and a ceiling so a dead bus cannot hang the run.
    initial begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask
    task automatic t_reset();
        apb(0, `OFF_P4_DIR, 0); `CHK(rd, 32'h7)
        apb(0, `OFF_P7_DIR, 0); `CHK(rd, 32'hF)
        apb(0, `OFF_ANALOG_SWITCH, 0); `CHK(rd, 32'h0)
        `CHK({oe4, oe5, oe7}, 9'h000)
        `CHK(shared_analog, 5'h1F)
    endtask
    task automatic t_output();
        apb(1, `OFF_P4_LATCH, 32'h5); apb(1, `OFF_P4_DIR, 32'h0); settle();
        `CHK(oe4, 3'h7)
        `CHK(o4, 3'h5)
        apb(0, `OFF_P4_READ, 0); `CHK(rd, 32'h5)
        apb(1, `OFF_P4_DIR, 32'h6); settle();
        `CHK(oe4, 3'h1)
    endtask
    task automatic t_pullup();
        apb(1, `OFF_P7_PULLUP, 32'hF); settle(); `CHK(pu7, 4'hF)
        apb(0, `OFF_P7_READ, 0); `CHK(rd, 32'hF)
        apb(1, `OFF_P7_DIR, 32'hE); settle(); `CHK(pu7, 4'hE)
    endtask
    task automatic t_analog();
        apb(1, `OFF_P4_DIR, 32'h7); apb(1, `OFF_P4_ANALOG, 32'h7);
        apb(0, `OFF_P4_ANALOG, 0); `CHK(rd, 32'h2)
        settle(); `CHK(an4, 3'h2)
        apb(0, `OFF_P4_READ, 0); `CHK(rd[1], 1'b0)
    endtask
    task automatic t_drain();
        apb(1, `OFF_P5_OUTTYPE, 32'h1); apb(1, `OFF_P5_LATCH, 32'h1);
        apb(1, `OFF_P5_DIR, 32'h0); settle(); `CHK(oe5[0], 1'b0)
        apb(1, `OFF_P5_LATCH, 32'h0); settle(); `CHK({oe5[0], o5[0]}, 2'h2)
    endtask
    task automatic t_switch();
        for (int c = 0; c < 8; c++) begin
            apb(1, `OFF_ANALOG_SWITCH, c); settle();
            apb(0, `OFF_ANALOG_SWITCH, 0); `CHK(rd, c)
            `CHK(shared_analog, c == 0 ? 5'h1F : c > 5 ? 5'h00 : 5'h1F >> (6 - c))
        end
    endtask
    task automatic t_unmapped();
        apb(1, 12'h00C, 32'hFF); `CHK(er, 1'b1)
        apb(0, 12'h00C, 0); `CHK({er, rd}, {1'b1, 32'h0})
    endtask
    // External references: shared pins 0 and 1 go analog and input before channel 0 is used.
    task automatic t_refs();
        apb(1, `OFF_P2_DIR, 32'h1C);
        settle();
        `CHK(port2_input_mode, 5'h1C)
        apb(1, `OFF_ANALOG_SWITCH, 32'h3);
        apb(1, `OFF_P2_DIR, 32'h1F);
        settle();
        `CHK({shared_analog, port2_input_mode}, 10'h07F)
        apb(0, `OFF_P2_DIR, 0);
        `CHK(rd, 32'h1F)
        `CHK(shared_analog[0], 1'b1)
    endtask
    // Board levels reach input pins; analog selection drops a pin's driver and pull-up.
    task automatic t_ports();
        ext4 <= 3'h5;
        apb(0, `OFF_P4_READ, 0);
        `CHK(rd, 32'h5)
        ext4 <= 3'h0;
        apb(1, `OFF_P4_PULLUP, 32'h7);
        settle();
        `CHK(pu4, 3'h5)
        apb(0, `OFF_P4_READ, 0);
        `CHK(rd, 32'h5)
        apb(1, `OFF_P5_PULLUP, 32'h3);
        apb(1, `OFF_P5_DIR, 32'h3);
        settle();
        `CHK(pu5, 2'h3)
        apb(1, `OFF_P5_ANALOG, 32'h3);
        settle();
        `CHK({an5, pu5, oe5}, 6'h30)
        apb(1, `OFF_P7_LATCH, 32'h9);
        settle();
        `CHK({o7, oe7}, 8'h91)
        apb(1, `OFF_P7_ANALOG, 32'hF);
        settle();
        `CHK({an7, oe7}, 8'h10)
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_reset(); t_output(); t_pullup(); t_analog(); t_drain(); t_switch(); t_unmapped();
        t_refs();
        t_ports();
        results();
    end
endmodule
`default_nettype wire
